/* ttc_defs.svh */
// Offsets, field positions, reset values and timing counts of the thermal throttle control
`ifndef TTC_DEFS_SVH
`define TTC_DEFS_SVH
`define TTC_OFF_CTRL 8'h00
`define TTC_OFF_ONDEM 8'h04
`define TTC_OFF_PERFREQ 8'h08
`define TTC_OFF_STEPTGT 8'h0c
`define TTC_OFF_THRESH 8'h10
`define TTC_OFF_SENSOR 8'h14
`define TTC_OFF_STATUS 8'h18
`define TTC_CTRL_MOD_EN 0
`define TTC_CTRL_STEP_EN 1
`define TTC_CTRL_FORCE 2
`define TTC_CTRL_IE_LO 3
`define TTC_OD_EN 4
`define TTC_SENSOR_VALID 31
`define TTC_ST_HOT 8
`define TTC_ST_OOS 9
`define TTC_ST_TCC 10
`define TTC_ST_PEND 11
`define TTC_ST_TRIP 12
`define TTC_ST_POINT_LO 16
`define TTC_CTRL_RST 8'h03
`define TTC_PERFREQ_RST 8'hff
`define TTC_STEPTGT_RST 8'h00
`define TTC_TJMAX 8'h64
`define TTC_TRIP_TEMP 8'h78
`define TTC_HYST 8'h02
`define TTC_AUTO_DUTY 3'h4
`define TTC_CLK_NS 10
`define TTC_STEP_WAIT_NS 10000
`define TTC_STEP_WAIT_CYC 16'(`TTC_STEP_WAIT_NS / `TTC_CLK_NS)
`define TTC_OOS_WAIT_NS 20000
`define TTC_OOS_WAIT_CYC 16'(`TTC_OOS_WAIT_NS / `TTC_CLK_NS)
`define TTC_RESP_OKAY 2'h0
`define TTC_RESP_SLVERR 2'h2
`endif

/* ttc_guard_model.sv */
// Model of the external thermal guard and the platform power control
`timescale 1ns/1ps
module ttc_guard_model #(
    parameter int SUPPLY_DLY = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic extHot,
    input wire logic hotAlertOe,
    input wire logic hotAlertOut,
    input wire logic overtempTripN,
    output logic hotPin,
    output logic supplyOn
);
    int offCnt;
    // Pulled-up pin: low while the device or the guard pulls it
    assign hotPin = ((hotAlertOe && !hotAlertOut) || extHot) ? 1'b0 : 1'b1;
    // Core supply drops a fixed time after the trip output falls
    always_ff @(posedge clk) begin
        if (rst) begin
            offCnt <= 0;
            supplyOn <= 1'b1;
        end else if (!overtempTripN) begin
            if (offCnt == SUPPLY_DLY) begin
                supplyOn <= 1'b0;
            end else begin
                offCnt <= offCnt + 1;
            end
        end
    end
endmodule

/* ttc_pkg.sv */
// Types shared by the thermal throttle control
package ttc_pkg;
    typedef enum logic [2:0] {
        TTC_IDLE,
        TTC_ONDEMAND,
        TTC_AUTO_MOD,
        TTC_STEP,
        TTC_STEP_MOD,
        TTC_TRIPPED
    } ttc_mode_e;
    typedef logic [7:0] ttc_point_t;
endpackage

/* ttc_top.sv */
// Thermal throttle control with AXI4-Lite register access
`timescale 1ns/1ps
`include "ttc_defs.svh"
module ttc_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] tempC,
    input wire logic lowPowerState,
    input wire logic pkgNormal,
    input wire logic hotAlertIn,
    output logic hotAlertOut,
    output logic hotAlertOe,
    output logic overtempTripN,
    output logic coreHalt,
    output logic clkRun,
    output logic [7:0] perfPoint,
    output logic thermIrq
);
    logic awHave_q, wHave_q, doWrite, wrOk;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic [7:0] ctrl_q;
    logic [4:0] od_q;
    ttc_pkg::ttc_point_t reqPt_q, stepTgt_q, perfPoint_q;
    logic [7:0] thr1_q, thr2_q, sensorOff;
    logic hotInt_q, hotSync1_q, hotSync2_q, pinPrev_q, hotOe_q, hotOut_q;
    logic [2:0] drvDly_q, slot_q, duty;
    logic extHot, pinLow, autoEn, autoHot, stepStuck, modulating, stepAct, freqPending;
    logic tripped_q, tripN_q, halt_q, clkRun_q, irq_q;
    logic [15:0] stepCnt_q, oosCnt_q;
    logic oosPrev_q, oosNow, near1Prev_q, near2Prev_q, near1, near2;
    logic [4:0] events, logs_q, logClr;
    logic [31:0] rdData;
    logic rdOk;
    ttc_pkg::ttc_mode_e mode_q, modeD;

    // Write channels: address and data taken in either order, then one response
    always_ff @(posedge clk) begin
        if (rst) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TTC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!awHave_q && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!wHave_q && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (doWrite) begin
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrOk ? `TTC_RESP_OKAY : `TTC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
    assign wrOk = awAddr_q <= `TTC_OFF_STATUS && awAddr_q[1:0] == 2'h0;

    // Writable registers; a frequency request write lands in reqPt_q
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= `TTC_CTRL_RST;
            od_q <= 5'h00;
            reqPt_q <= `TTC_PERFREQ_RST;
            stepTgt_q <= `TTC_STEPTGT_RST;
            thr1_q <= 8'h00;
            thr2_q <= 8'h00;
        end else if (doWrite) begin
            case (awAddr_q)
                `TTC_OFF_CTRL: ctrl_q <= wStrb_q[0] ? wData_q[7:0] : ctrl_q;
                `TTC_OFF_ONDEM: od_q <= wStrb_q[0] ? wData_q[4:0] : od_q;
                `TTC_OFF_PERFREQ: reqPt_q <= wStrb_q[0] ? wData_q[7:0] : reqPt_q;
                `TTC_OFF_STEPTGT: stepTgt_q <= wStrb_q[0] ? wData_q[7:0] : stepTgt_q;
                `TTC_OFF_THRESH: begin
                    thr1_q <= wStrb_q[0] ? wData_q[7:0] : thr1_q;
                    thr2_q <= wStrb_q[1] ? wData_q[15:8] : thr2_q;
                end
                default: ;
            endcase
        end
    end

    // Read channel: data answered one cycle after the address is taken
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TTC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdData;
            s_axi_rresp <= rdOk ? `TTC_RESP_OKAY : `TTC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // Read decode; unmapped offsets read zero with an error response
    always_comb begin
        rdData = 32'h0000_0000;
        rdOk = 1'b1;
        case (s_axi_araddr)
            `TTC_OFF_CTRL: rdData[7:0] = ctrl_q;
            `TTC_OFF_ONDEM: rdData[4:0] = od_q;
            `TTC_OFF_PERFREQ: rdData[7:0] = reqPt_q;
            `TTC_OFF_STEPTGT: rdData[7:0] = stepTgt_q;
            `TTC_OFF_THRESH: rdData[15:0] = {thr2_q, thr1_q};
            `TTC_OFF_SENSOR: begin
                rdData[7:0] = sensorOff;
                rdData[`TTC_SENSOR_VALID] = pkgNormal;
            end
            `TTC_OFF_STATUS: begin
                rdData[4:0] = logs_q;
                rdData[`TTC_ST_HOT] = pinLow;
                rdData[`TTC_ST_OOS] = oosNow;
                rdData[`TTC_ST_TCC] = mode_q != ttc_pkg::TTC_IDLE;
                rdData[`TTC_ST_PEND] = freqPending;
                rdData[`TTC_ST_TRIP] = tripped_q;
                rdData[`TTC_ST_POINT_LO +: 8] = perfPoint_q;
            end
            default: rdOk = 1'b0;
        endcase
    end

    // Internal trip point with hysteresis
    always_ff @(posedge clk) begin
        if (rst) begin
            hotInt_q <= 1'b0;
        end else if (tempC >= `TTC_TJMAX) begin
            hotInt_q <= 1'b1;
        end else if (tempC < `TTC_TJMAX - `TTC_HYST) begin
            hotInt_q <= 1'b0;
        end
    end

    // Hot alert pin: synchroniser, own drive and echo mask
    always_ff @(posedge clk) begin
        if (rst) begin
            hotSync1_q <= 1'b1;
            hotSync2_q <= 1'b1;
            pinPrev_q <= 1'b0;
            hotOe_q <= 1'b0;
            hotOut_q <= 1'b0;
            drvDly_q <= 3'h0;
        end else begin
            hotSync1_q <= hotAlertIn;
            hotSync2_q <= hotSync1_q;
            pinPrev_q <= pinLow;
            drvDly_q <= {drvDly_q[1:0], hotOe_q};
            if (hotInt_q) begin
                hotOe_q <= hotOe_q || !lowPowerState;
            end else begin
                hotOe_q <= hotOe_q && lowPowerState;
            end
        end
    end
    assign pinLow = !hotSync2_q;
    assign extHot = pinLow && !hotOe_q && drvDly_q == 3'h0;

    // Catastrophic trip, held until reset
    always_ff @(posedge clk) begin
        if (rst) begin
            tripped_q <= 1'b0;
            tripN_q <= 1'b1;
            halt_q <= 1'b0;
        end else if (tempC >= `TTC_TRIP_TEMP || tripped_q) begin
            tripped_q <= 1'b1;
            tripN_q <= 1'b0;
            halt_q <= 1'b1;
        end
    end

    // Mode selection between trip, automatic, on-demand and idle
    assign autoEn = ctrl_q[`TTC_CTRL_MOD_EN] || ctrl_q[`TTC_CTRL_STEP_EN];
    assign autoHot = autoEn && (hotInt_q || extHot);
    assign stepStuck = stepCnt_q == `TTC_STEP_WAIT_CYC;
    always_comb begin
        modeD = ttc_pkg::TTC_IDLE;
        if (tripped_q) begin
            modeD = ttc_pkg::TTC_TRIPPED;
        end else if (autoHot) begin
            if (ctrl_q[`TTC_CTRL_STEP_EN]) begin
                // Force only counts for the internal sensor
                if (ctrl_q[`TTC_CTRL_FORCE] && hotInt_q && stepStuck) begin
                    modeD = ttc_pkg::TTC_STEP_MOD;
                end else begin
                    modeD = ttc_pkg::TTC_STEP;
                end
            end else begin
                modeD = ttc_pkg::TTC_AUTO_MOD;
            end
        end else if (od_q[`TTC_OD_EN]) begin
            modeD = ttc_pkg::TTC_ONDEMAND;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= ttc_pkg::TTC_IDLE;
        end else begin
            mode_q <= modeD;
        end
    end

    // Per-mode duty and step selection
    always_comb begin
        duty = `TTC_AUTO_DUTY;
        modulating = 1'b0;
        stepAct = 1'b0;
        case (mode_q)
            ttc_pkg::TTC_ONDEMAND: begin
                modulating = 1'b1;
                duty = (od_q[3:1] == 3'h0) ? `TTC_AUTO_DUTY : od_q[3:1];
            end
            ttc_pkg::TTC_AUTO_MOD: modulating = 1'b1;
            ttc_pkg::TTC_STEP: stepAct = 1'b1;
            ttc_pkg::TTC_STEP_MOD: begin
                modulating = 1'b1;
                stepAct = 1'b1;
            end
            default: ;
        endcase
    end

    // Eight-slot gating of the core clock
    always_ff @(posedge clk) begin
        if (rst) begin
            slot_q <= 3'h0;
            clkRun_q <= 1'b1;
        end else begin
            slot_q <= slot_q + 3'h1;
            clkRun_q <= !tripped_q && (!modulating || slot_q < duty);
        end
    end

    // Operating point: throttle target, software point and the lower of both
    assign freqPending = stepAct && reqPt_q > stepTgt_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            perfPoint_q <= `TTC_PERFREQ_RST;
        end else if (stepAct) begin
            perfPoint_q <= (reqPt_q < stepTgt_q) ? reqPt_q : stepTgt_q;
        end else begin
            perfPoint_q <= reqPt_q;
        end
    end

    // Throttle duration counters for force and out-of-spec
    always_ff @(posedge clk) begin
        if (rst) begin
            stepCnt_q <= 16'h0000;
            oosCnt_q <= 16'h0000;
        end else begin
            if (stepAct && hotInt_q) begin
                stepCnt_q <= stepStuck ? stepCnt_q : stepCnt_q + 16'h0001;
            end else begin
                stepCnt_q <= 16'h0000;
            end
            if ((mode_q == ttc_pkg::TTC_AUTO_MOD || stepAct) && hotInt_q) begin
                oosCnt_q <= oosNow ? oosCnt_q : oosCnt_q + 16'h0001;
            end else begin
                oosCnt_q <= 16'h0000;
            end
        end
    end
    assign oosNow = oosCnt_q == `TTC_OOS_WAIT_CYC;

    // Sensor offset below the maximum and threshold proximity
    assign sensorOff = (tempC >= `TTC_TJMAX) ? 8'h00 : `TTC_TJMAX - tempC;
    assign near1 = pkgNormal && sensorOff <= thr1_q;
    assign near2 = pkgNormal && sensorOff <= thr2_q;

    // Events into sticky logs, set wins over a write-one clear
    assign events = {near2 != near2Prev_q, near1 != near1Prev_q, oosNow && !oosPrev_q,
                     !pinLow && pinPrev_q, pinLow && !pinPrev_q};
    assign logClr = (doWrite && awAddr_q == `TTC_OFF_STATUS && wStrb_q[0]) ? wData_q[4:0] : 5'h00;
    always_ff @(posedge clk) begin
        if (rst) begin
            logs_q <= 5'h00;
            irq_q <= 1'b0;
            oosPrev_q <= 1'b0;
            near1Prev_q <= 1'b0;
            near2Prev_q <= 1'b0;
        end else begin
            logs_q <= (logs_q & ~logClr) | events;
            irq_q <= |(events & ctrl_q[`TTC_CTRL_IE_LO +: 5]);
            oosPrev_q <= oosNow;
            near1Prev_q <= near1;
            near2Prev_q <= near2;
        end
    end

    assign hotAlertOut = hotOut_q;
    assign hotAlertOe = hotOe_q;
    assign overtempTripN = tripN_q;
    assign coreHalt = halt_q;
    assign clkRun = clkRun_q;
    assign perfPoint = perfPoint_q;
    assign thermIrq = irq_q;

    // Checks on the throttle behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    trip_hold_a: assert property (tempC >= `TTC_TRIP_TEMP |=> !overtempTripN ##1 !overtempTripN)
        else $error("trip output not asserted");
    drive_hot_a: assert property (hotInt_q && !lowPowerState && !tripped_q |=> hotAlertOe)
        else $error("hot alert not driven");
    no_new_drive_a: assert property (lowPowerState && !hotAlertOe |=> !hotAlertOe)
        else $error("hot alert newly driven in low power");
    keep_drive_a: assert property (lowPowerState && hotAlertOe |=> hotAlertOe)
        else $error("hot alert dropped in low power");
    auto_half_a: assert property (mode_q == ttc_pkg::TTC_AUTO_MOD && slot_q == 3'h4
        |=> !clkRun) else $error("auto duty not half");
    od_duty_a: assert property (mode_q == ttc_pkg::TTC_ONDEMAND && od_q[3:1] != 3'h0 && !tripped_q
        && slot_q < od_q[3:1] |=> clkRun) else $error("on-demand duty wrong");
    step_low_a: assert property (stepAct && $stable(reqPt_q) && $stable(stepTgt_q)
        |=> perfPoint <= $past(stepTgt_q)) else $error("step target exceeded");
    restore_pt_a: assert property (mode_q == ttc_pkg::TTC_IDLE && $stable(reqPt_q)
        |=> perfPoint == $past(reqPt_q)) else $error("software point not restored");
    ext_step_a: assert property (extHot && !hotInt_q && ctrl_q[1:0] == 2'h3 && !tripped_q
        |=> mode_q == ttc_pkg::TTC_STEP) else $error("external hot mode wrong");
    sensor_max_a: assert property (sensorOff <= `TTC_TJMAX)
        else $error("sensor offset out of range");
    od_cover_c: cover property (mode_q == ttc_pkg::TTC_ONDEMAND ##1 !clkRun);
    force_cover_c: cover property (mode_q == ttc_pkg::TTC_STEP_MOD);
    irq_cover_c: cover property (thermIrq && logs_q[2]);
endmodule

/* ttc_top_tb.sv */
// Self-checking bench for the thermal throttle control
`timescale 1ns/1ps
`include "ttc_defs.svh"
module ttc_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awAddr = 8'h00, arAddr = 8'h00, tempC = 8'h32;
    logic [31:0] wData = 32'h0, rData, seed = 32'h758fe523;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic lowPower = 1'b0, pkgNormal = 1'b1, extHot = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid, hotPin, supplyOn;
    logic hotAlertOut, hotAlertOe, overtempTripN, coreHalt, clkRun, thermIrq;
    logic [1:0] bResp, rResp;
    logic [7:0] perfPoint;
    int fails = 0;
    int checks = 0;
    int irqCnt = 0;
    // Clock and interrupt pulse count
    always #5 clk = ~clk;
    always @(posedge clk) if (thermIrq === 1'b1) irqCnt <= irqCnt + 1;
    ttc_top ttc_top_i (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .tempC(tempC),
        .lowPowerState(lowPower), .pkgNormal(pkgNormal), .hotAlertIn(hotPin),
        .hotAlertOut(hotAlertOut), .hotAlertOe(hotAlertOe), .overtempTripN(overtempTripN),
        .coreHalt(coreHalt), .clkRun(clkRun), .perfPoint(perfPoint), .thermIrq(thermIrq));
    ttc_guard_model ttc_guard_model_i (.clk(clk), .rst(rst), .extHot(extHot),
        .hotAlertOe(hotAlertOe), .hotAlertOut(hotAlertOut), .overtempTripN(overtempTripN),
        .hotPin(hotPin), .supplyOn(supplyOn));
    // Xorshift source and expectations
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] sensorExp(input logic [7:0] t, input logic v);
        logic [7:0] off;
        off = (t >= `TTC_TJMAX) ? 8'h00 : `TTC_TJMAX - t;
        return {v, 23'h0, off};
    endfunction
    function automatic int dutyExp(input logic [2:0] d, input int n);
        return n * ((d == 3'h0) ? 4 : int'(d)) / 8;
    endfunction
    // Comparison, verdict and hang handling
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkNear(input string what, input int exp, input int got, input int tol);
        checks++;
        if (got < exp - tol || got > exp + tol) begin
            fails++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic timeout(input string what);
        fails++;
        $display("CHECK FAILED %s expected answer seen none", what);
        conclude();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Bus write: address and data together, bready held until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        for (n = 0; !(aw && w); n++) begin
            if (n == 50) timeout("write");
            @(posedge clk);
            if (!aw && awReady === 1'b1) begin
                aw = 1'b1;
                awValid <= 1'b0;
            end
            if (!w && wReady === 1'b1) begin
                w = 1'b1;
                wValid <= 1'b0;
            end
        end
        for (n = 0; bValid !== 1'b1; n++) begin
            if (n == 50) timeout("write response");
            @(posedge clk);
        end
        chk("write response", er, bResp);
        bReady <= 1'b0;
        @(posedge clk);
    endtask
    // Bus read with masked data compare
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
            input logic [1:0] er);
        int n;
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        for (n = 0; n == 0 || arReady !== 1'b1; n++) begin
            if (n == 50) timeout("read");
            @(posedge clk);
        end
        arValid <= 1'b0;
        for (n = 0; rValid !== 1'b1; n++) begin
            if (n == 50) timeout("read data");
            @(posedge clk);
        end
        chk("read data", e & m, rData & m);
        chk("read response", er, rResp);
        rReady <= 1'b0;
        @(posedge clk);
    endtask
    task automatic measure(input int n, output int hi);
        hi = 0;
        repeat (n) begin
            @(posedge clk);
            if (clkRun === 1'b1) hi++;
        end
    endtask
    // Main sequence
    initial begin
        int hi;
        int n0;
        logic [7:0] t;
        logic v;
        cyc(8);
        rst <= 1'b0;
        cyc(2);
        rd(`TTC_OFF_CTRL, `TTC_CTRL_RST, 32'hff, `TTC_RESP_OKAY);
        rd(`TTC_OFF_PERFREQ, `TTC_PERFREQ_RST, 32'hff, `TTC_RESP_OKAY);
        rd(`TTC_OFF_STEPTGT, `TTC_STEPTGT_RST, 32'hff, `TTC_RESP_OKAY);
        rd(8'h1c, 32'h0, 32'hffffffff, `TTC_RESP_SLVERR);
        wr(8'h02, 32'h0, `TTC_RESP_SLVERR);
        for (int i = 0; i < 7; i++) begin
            t = (i == 6) ? 8'h6e : 8'(rnd() % 32'h60);
            v = 1'(rnd());
            tempC <= t;
            pkgNormal <= v;
            cyc(4);
            rd(`TTC_OFF_SENSOR, sensorExp(t, v), 32'hffffffff, `TTC_RESP_OKAY);
        end
        tempC <= 8'h32;
        pkgNormal <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr(`TTC_OFF_ONDEM, {27'h0, 1'b1, 3'(i), 1'b0}, `TTC_RESP_OKAY);
            cyc(4);
            measure(512, hi);
            chkNear("on-demand duty", dutyExp(3'(i), 512), hi, 16);
        end
        wr(`TTC_OFF_CTRL, 32'h01, `TTC_RESP_OKAY);
        tempC <= 8'h64;
        cyc(6);
        measure(512, hi);
        chkNear("automatic duty", 256, hi, 16);
        chk("hot alert drive", 1'b1, hotAlertOe);
        chk("hot alert level", 1'b0, hotAlertOut);
        tempC <= 8'h63;
        cyc(4);
        chk("hot alert hold", 1'b1, hotAlertOe);
        tempC <= 8'h61;
        cyc(4);
        chk("hot alert release", 1'b0, hotAlertOe);
        wr(`TTC_OFF_ONDEM, 32'h0, `TTC_RESP_OKAY);
        wr(`TTC_OFF_CTRL, 32'h03, `TTC_RESP_OKAY);
        wr(`TTC_OFF_STEPTGT, 32'h10, `TTC_RESP_OKAY);
        wr(`TTC_OFF_PERFREQ, 32'h80, `TTC_RESP_OKAY);
        tempC <= 8'h64;
        cyc(6);
        chk("step point", 8'h10, perfPoint);
        measure(64, hi);
        chkNear("step no modulation", 64, hi, 0);
        wr(`TTC_OFF_PERFREQ, 32'hc0, `TTC_RESP_OKAY);
        cyc(3);
        chk("higher deferred", 8'h10, perfPoint);
        rd(`TTC_OFF_STATUS, 32'h800, 32'h800, `TTC_RESP_OKAY);
        tempC <= 8'h5a;
        cyc(6);
        chk("restored point", 8'hc0, perfPoint);
        tempC <= 8'h64;
        cyc(6);
        wr(`TTC_OFF_PERFREQ, 32'h08, `TTC_RESP_OKAY);
        cyc(3);
        chk("lower at once", 8'h08, perfPoint);
        tempC <= 8'h5a;
        cyc(6);
        lowPower <= 1'b1;
        tempC <= 8'h64;
        cyc(6);
        chk("low power no alert", 1'b0, hotAlertOe);
        lowPower <= 1'b0;
        cyc(6);
        lowPower <= 1'b1;
        tempC <= 8'h5a;
        cyc(6);
        chk("alert kept", 1'b1, hotAlertOe);
        lowPower <= 1'b0;
        cyc(6);
        chk("alert dropped", 1'b0, hotAlertOe);
        wr(`TTC_OFF_PERFREQ, 32'h80, `TTC_RESP_OKAY);
        wr(`TTC_OFF_CTRL, 32'h07, `TTC_RESP_OKAY);
        tempC <= 8'h32;
        extHot <= 1'b1;
        cyc(8);
        chk("external step", 8'h10, perfPoint);
        measure(64, hi);
        chkNear("external no force", 64, hi, 0);
        rd(`TTC_OFF_STATUS, 32'h400, 32'h400, `TTC_RESP_OKAY);
        wr(`TTC_OFF_CTRL, 32'h01, `TTC_RESP_OKAY);
        cyc(6);
        measure(512, hi);
        chkNear("external modulation", 256, hi, 16);
        extHot <= 1'b0;
        wr(`TTC_OFF_THRESH, 32'h3005, `TTC_RESP_OKAY);
        wr(`TTC_OFF_CTRL, 32'h5b, `TTC_RESP_OKAY);
        cyc(8);
        wr(`TTC_OFF_STATUS, 32'h1f, `TTC_RESP_OKAY);
        n0 = irqCnt;
        tempC <= 8'h60;
        cyc(8);
        tempC <= 8'h64;
        cyc(8);
        tempC <= 8'h60;
        cyc(8);
        chk("interrupt count", 3, irqCnt - n0);
        rd(`TTC_OFF_STATUS, 32'h1b, 32'h1f, `TTC_RESP_OKAY);
        wr(`TTC_OFF_STATUS, 32'h0b, `TTC_RESP_OKAY);
        rd(`TTC_OFF_STATUS, 32'h10, 32'h1f, `TTC_RESP_OKAY);
        wr(`TTC_OFF_CTRL, 32'h07, `TTC_RESP_OKAY);
        tempC <= 8'h64;
        cyc(2100);
        measure(512, hi);
        chkNear("forced modulation", 256, hi, 16);
        rd(`TTC_OFF_STATUS, 32'h204, 32'h204, `TTC_RESP_OKAY);
        tempC <= 8'h78;
        cyc(3);
        chk("trip output", 1'b0, overtempTripN);
        chk("core halt", 1'b1, coreHalt);
        chk("clock stopped", 1'b0, clkRun);
        tempC <= 8'h32;
        cyc(10);
        chk("trip sticky", 1'b0, overtempTripN);
        chk("supply removed", 1'b0, supplyOn);
        rst <= 1'b1;
        cyc(8);
        rst <= 1'b0;
        cyc(2);
        chk("trip cleared", 1'b1, overtempTripN);
        rd(`TTC_OFF_CTRL, `TTC_CTRL_RST, 32'hff, `TTC_RESP_OKAY);
        conclude();
    end
endmodule
